// ===== olp_consts.svh
// constants for the list pointer register bank
// What this block does
// - The base address is a writable 24-bit field in bits 31 to 8, reset to zero.
// - Bits 7 to 0 of the base register always read as zero, for 256-byte alignment.
// - The communication area holds control structures and the interrupt table for both sides.
// - The periodic pointer is read-only, address in bits 31 to 4, low bits reserved, reset zero.
// - The controller updates the periodic pointer each time it finishes a periodic descriptor.
// - The controller uses the periodic pointer to find a periodic list head for this frame.
// - A software read of the periodic current pointer returns its live value.
// - The control head holds the first control descriptor address in bits 31 to 4, reset zero.
// - The registers sit at offsets 18h, 1Ch and 20h of the memory space.
// - The controller starts control list traversal at the control head address.
`ifndef OLP_CONSTS_SVH
`define OLP_CONSTS_SVH

`define OLP_ADDR_W 12
`define OLP_OFF_COMM_AREA 12'h018
`define OLP_OFF_PERIODIC 12'h01C
`define OLP_OFF_CTRL_HEAD 12'h020
`define OLP_COMM_LSB 8
`define OLP_COMM_W 24
`define OLP_PTR_LSB 4
`define OLP_PTR_W 28
`define OLP_COMM_RST 24'h000000
`define OLP_PTR_RST 28'h0000000
`define OLP_RDATA_RST 32'h00000000

`endif

// ===== olp_pkg.sv
// types for the list pointer register bank
package olp_pkg;
	typedef enum logic [1:0] {
		OLP_SEL_NONE = 2'b00,
		OLP_SEL_COMM = 2'b01,
		OLP_SEL_PER = 2'b10,
		OLP_SEL_CTRL = 2'b11
	} olp_sel_t;
endpackage

// ===== olp_ptr_field.sv
// one pointer field with clear and load
`timescale 1ns/100ps
module olp_ptr_field #(
	parameter int W = 28
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic clr_i,
	input wire logic ld_i,
	input wire logic [W-1:0] ld_data_i,
	// value
	output logic [W-1:0] val_o
);
	logic [W-1:0] val_reg;
	logic [W-1:0] val_next;

	always_comb begin
		val_next = val_reg;
		if (clr_i) begin
			val_next = '0;
		end else if (ld_i) begin
			val_next = ld_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			val_reg <= '0;
		end else begin
			val_reg <= val_next;
		end
	end

	assign val_o = val_reg;
endmodule

// ===== olp_list_ptr_regs.sv
// communication area base, periodic current and control head pointer registers
`timescale 1ns/100ps
`include "olp_consts.svh"
module olp_list_ptr_regs (
	// clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic soft_rst_i,
	// memory-space register access
	input wire logic [`OLP_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [3:0] reg_be_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic reg_ack_o,
	// list engine side
	input wire logic per_upd_i,
	input wire logic [`OLP_PTR_W-1:0] per_upd_addr_i,
	input wire logic ctrl_head_ld_i,
	input wire logic [`OLP_PTR_W-1:0] ctrl_head_ld_addr_i,
	output logic [`OLP_COMM_W-1:0] comm_area_base_o,
	output logic [`OLP_PTR_W-1:0] periodic_desc_addr_field_o,
	output logic [`OLP_PTR_W-1:0] control_head_addr_field_o
);
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	olp_pkg::olp_sel_t sel;
	logic comm_wr;
	logic [`OLP_COMM_W-1:0] comm_merged;

	always_comb begin
		case (reg_addr_i)
			`OLP_OFF_COMM_AREA: sel = olp_pkg::OLP_SEL_COMM;
			`OLP_OFF_PERIODIC: sel = olp_pkg::OLP_SEL_PER;
			`OLP_OFF_CTRL_HEAD: sel = olp_pkg::OLP_SEL_CTRL;
			default: sel = olp_pkg::OLP_SEL_NONE;
		endcase
	end

	// ----------------------------------------
	// pointer fields
	// ----------------------------------------
	// byte lane 0 holds only forced-zero bits
	always_comb begin
		comm_merged = comm_area_base_o;
		for (int b = 1; b < 4; b++) begin
			if (reg_be_i[b]) begin
				comm_merged[(b-1)*8 +: 8] = reg_wdata_i[b*8 +: 8];
			end
		end
	end

	assign comm_wr = reg_wr_i && (sel == olp_pkg::OLP_SEL_COMM);

	olp_ptr_field #(.W(`OLP_COMM_W)) u_comm (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(soft_rst_i),
		.ld_i(comm_wr),
		.ld_data_i(comm_merged),
		.val_o(comm_area_base_o)
	);

	// software writes never reach this field
	olp_ptr_field #(.W(`OLP_PTR_W)) u_periodic (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(soft_rst_i),
		.ld_i(per_upd_i),
		.ld_data_i(per_upd_addr_i),
		.val_o(periodic_desc_addr_field_o)
	);

	olp_ptr_field #(.W(`OLP_PTR_W)) u_ctrl_head (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(soft_rst_i),
		.ld_i(ctrl_head_ld_i),
		.ld_data_i(ctrl_head_ld_addr_i),
		.val_o(control_head_addr_field_o)
	);

	// ----------------------------------------
	// read data and acknowledge
	// ----------------------------------------
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic ack_reg;
	logic ack_next;

	always_comb begin
		rdata_next = rdata_reg;
		ack_next = reg_wr_i || reg_rd_i;
		if (reg_rd_i) begin
			case (sel)
				olp_pkg::OLP_SEL_COMM: begin
					rdata_next = {comm_area_base_o, 8'h00};
				end
				olp_pkg::OLP_SEL_PER: begin
					rdata_next = {periodic_desc_addr_field_o, 4'h0};
				end
				olp_pkg::OLP_SEL_CTRL: begin
					rdata_next = {control_head_addr_field_o, 4'h0};
				end
				default: begin
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= `OLP_RDATA_RST;
			ack_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_ack_o = ack_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_comm_low_zero;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_COMM_AREA) |=> (reg_rdata_o[7:0] == 8'h00);
	endproperty
	a_comm_low_zero: assert property (p_comm_low_zero) else $error("base low byte set");

	property p_comm_write;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA && reg_be_i == 4'hF && !soft_rst_i)
			|=> (comm_area_base_o == $past(reg_wdata_i[31:8]));
	endproperty
	a_comm_write: assert property (p_comm_write) else $error("base write not stored");

	property p_comm_roundtrip;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA && reg_be_i == 4'hF
			&& reg_wdata_i == 32'hFFFFFFFF && !soft_rst_i)
			##1 (reg_rd_i && reg_addr_i == `OLP_OFF_COMM_AREA && !reg_wr_i)
			|=> (reg_rdata_o == 32'hFFFFFF00);
	endproperty
	a_comm_roundtrip: assert property (p_comm_roundtrip) else $error("probe wrong");

	property p_per_update;
		@(posedge clk_i) disable iff (rst_i)
		(per_upd_i && !soft_rst_i) |=> (periodic_desc_addr_field_o == $past(per_upd_addr_i));
	endproperty
	a_per_update: assert property (p_per_update) else $error("periodic not updated");

	property p_per_sw_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && !per_upd_i && !soft_rst_i) |=> $stable(periodic_desc_addr_field_o);
	endproperty
	a_per_sw_ignored: assert property (p_per_sw_ignored) else $error("periodic written");

	property p_per_live_read;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_PERIODIC)
			|=> (reg_rdata_o == {$past(periodic_desc_addr_field_o), 4'h0});
	endproperty
	a_per_live_read: assert property (p_per_live_read) else $error("periodic read stale");

	property p_ctrl_load;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_head_ld_i && !soft_rst_i)
			|=> (control_head_addr_field_o == $past(ctrl_head_ld_addr_i));
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control head not loaded");

	property p_ctrl_read;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_CTRL_HEAD)
			|=> (reg_rdata_o[3:0] == 4'h0
			&& reg_rdata_o[31:4] == $past(control_head_addr_field_o));
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control head read wrong");

	property p_soft_clear;
		@(posedge clk_i) disable iff (rst_i)
		soft_rst_i |=> (comm_area_base_o == `OLP_COMM_RST
			&& periodic_desc_addr_field_o == `OLP_PTR_RST
			&& control_head_addr_field_o == `OLP_PTR_RST);
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear");

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i || reg_rd_i) |=> reg_ack_o ##1 (reg_ack_o == $past(reg_wr_i || reg_rd_i));
	endproperty
	a_ack: assert property (p_ack) else $error("access not acknowledged");

	// ----------------------------------------
	// hold, lane and priority checks
	// ----------------------------------------
	property p_ack_idle;
		@(posedge clk_i) disable iff (rst_i)
		!(reg_wr_i || reg_rd_i) |=> !reg_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

	property p_unmapped_rd;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i != `OLP_OFF_COMM_AREA && reg_addr_i != `OLP_OFF_PERIODIC
			&& reg_addr_i != `OLP_OFF_CTRL_HEAD) |=> (reg_rdata_o == `OLP_RDATA_RST);
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read set");

	property p_rdata_hold;
		@(posedge clk_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

	property p_comm_read;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_COMM_AREA)
			|=> (reg_rdata_o[31:8] == $past(comm_area_base_o));
	endproperty
	a_comm_read: assert property (p_comm_read) else $error("base read wrong");

	property p_per_read_low;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_PERIODIC) |=> (reg_rdata_o[3:0] == 4'h0);
	endproperty
	a_per_read_low: assert property (p_per_read_low) else $error("periodic low set");

	property p_ctrl_read_low;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && reg_addr_i == `OLP_OFF_CTRL_HEAD) |=> (reg_rdata_o[3:0] == 4'h0);
	endproperty
	a_ctrl_read_low: assert property (p_ctrl_read_low) else $error("head low set");

	property p_comm_keep;
		@(posedge clk_i) disable iff (rst_i)
		(!(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA) && !soft_rst_i)
			|=> $stable(comm_area_base_o);
	endproperty
	a_comm_keep: assert property (p_comm_keep) else $error("base moved");

	property p_comm_rd_keep;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && !reg_wr_i && !soft_rst_i) |=> $stable(comm_area_base_o);
	endproperty
	a_comm_rd_keep: assert property (p_comm_rd_keep) else $error("base moved on read");

	property p_per_keep;
		@(posedge clk_i) disable iff (rst_i)
		(!per_upd_i && !soft_rst_i) |=> $stable(periodic_desc_addr_field_o);
	endproperty
	a_per_keep: assert property (p_per_keep) else $error("periodic moved");

	property p_per_rd_keep;
		@(posedge clk_i) disable iff (rst_i)
		(reg_rd_i && !per_upd_i && !soft_rst_i) |=> $stable(periodic_desc_addr_field_o);
	endproperty
	a_per_rd_keep: assert property (p_per_rd_keep) else $error("periodic moved on read");

	property p_ctrl_keep;
		@(posedge clk_i) disable iff (rst_i)
		(!ctrl_head_ld_i && !soft_rst_i) |=> $stable(control_head_addr_field_o);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("head moved");

	property p_ctrl_sw_ignored;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && !ctrl_head_ld_i && !soft_rst_i) |=> $stable(control_head_addr_field_o);
	endproperty
	a_ctrl_sw_ignored: assert property (p_ctrl_sw_ignored) else $error("head written");

	property p_comm_lane1;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA && !reg_be_i[1] && !soft_rst_i)
			|=> (comm_area_base_o[7:0] == $past(comm_area_base_o[7:0]));
	endproperty
	a_comm_lane1: assert property (p_comm_lane1) else $error("lane 1 written");

	property p_comm_lane2;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA && !reg_be_i[2] && !soft_rst_i)
			|=> (comm_area_base_o[15:8] == $past(comm_area_base_o[15:8]));
	endproperty
	a_comm_lane2: assert property (p_comm_lane2) else $error("lane 2 written");

	property p_comm_lane3;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && reg_addr_i == `OLP_OFF_COMM_AREA && !reg_be_i[3] && !soft_rst_i)
			|=> (comm_area_base_o[23:16] == $past(comm_area_base_o[23:16]));
	endproperty
	a_comm_lane3: assert property (p_comm_lane3) else $error("lane 3 written");

	property p_soft_wins;
		@(posedge clk_i) disable iff (rst_i)
		(soft_rst_i && reg_wr_i) |=> (comm_area_base_o == `OLP_COMM_RST);
	endproperty
	a_soft_wins: assert property (p_soft_wins) else $error("write beat soft reset");

	property p_per_soft_wins;
		@(posedge clk_i) disable iff (rst_i)
		(soft_rst_i && per_upd_i) |=> (periodic_desc_addr_field_o == `OLP_PTR_RST);
	endproperty
	a_per_soft_wins: assert property (p_per_soft_wins) else $error("update beat reset");

	property p_ctrl_soft_wins;
		@(posedge clk_i) disable iff (rst_i)
		(soft_rst_i && ctrl_head_ld_i) |=> (control_head_addr_field_o == `OLP_PTR_RST);
	endproperty
	a_ctrl_soft_wins: assert property (p_ctrl_soft_wins) else $error("load beat reset");

	property p_rdata_wr_keep;
		@(posedge clk_i) disable iff (rst_i)
		(reg_wr_i && !reg_rd_i) |=> $stable(reg_rdata_o);
	endproperty
	a_rdata_wr_keep: assert property (p_rdata_wr_keep) else $error("write moved read data");
endmodule

// ===== olp_host_model.sv
// host driver model issuing memory-space register accesses
`timescale 1ns/100ps
module olp_host_model (
	// clock and answer
	input wire logic clk_i,
	input wire logic [31:0] rdata_i,
	input wire logic ack_i,
	// request
	output logic [11:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [3:0] be_o,
	output logic [31:0] wdata_o
);
	initial begin
		addr_o = 12'h000;
		wr_o = 1'b0;
		rd_o = 1'b0;
		be_o = 4'h0;
		wdata_o = 32'h00000000;
	end
	// one access: strobe one cycle, answer sampled after the next edge
	task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] q, output logic k);
		@(posedge clk_i);
		addr_o <= a;
		wr_o <= w;
		rd_o <= ~w;
		be_o <= b;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		// released address and data lines carry junk, not the old value
		addr_o <= ~a;
		wdata_o <= ~d;
		#1;
		q = rdata_i;
		k = ack_i;
	endtask
endmodule

// ===== ohci_list_pointer_regs_tb.sv
// self-checking bench for the list pointer register bank
`timescale 1ns/100ps
module ohci_list_pointer_regs_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic soft_rst_i = 1'b0;
	logic per_upd_i = 1'b0;
	logic ctrl_head_ld_i = 1'b0;
	logic [27:0] per_upd_addr_i = 28'h0000000;
	logic [27:0] ctrl_head_ld_addr_i = 28'h0000000;
	logic [11:0] addr;
	logic wr, rd, ack;
	logic [3:0] be;
	logic [31:0] wdata, rdata, q, d;
	logic [23:0] comm_o;
	logic [27:0] per_o, ctrl_o;
	logic k;
	int fails = 0;
	int total_checks = 0;
	int m_comm, m_per, m_ctrl, i;
	always #5 clk_i = ~clk_i;
	olp_host_model host_u (.clk_i(clk_i), .rdata_i(rdata), .ack_i(ack), .addr_o(addr),
		.wr_o(wr), .rd_o(rd), .be_o(be), .wdata_o(wdata));
	olp_list_ptr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
		.reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_be_i(be),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
		.per_upd_i(per_upd_i), .per_upd_addr_i(per_upd_addr_i),
		.ctrl_head_ld_i(ctrl_head_ld_i), .ctrl_head_ld_addr_i(ctrl_head_ld_addr_i),
		.comm_area_base_o(comm_o), .periodic_desc_addr_field_o(per_o),
		.control_head_addr_field_o(ctrl_o));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [11:0] a, input int exp);
		host_u.acc(1'b0, a, 4'hF, 32'h0, q, k);
		chk({31'h0, k}, 32'h1);
		chk(q, 32'(exp));
	endtask
	task automatic wrc(input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
		host_u.acc(1'b1, a, b, v, q, k);
		chk({31'h0, k}, 32'h1);
	endtask
	task automatic final_report;
		$display("fails=%0d total_checks=%0d", fails, total_checks);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		final_report();
	end
	initial begin
		void'($urandom(32'h2F56));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		m_comm = 0;
		m_per = 0;
		m_ctrl = 0;
		rdc(12'h018, 0);
		rdc(12'h01C, 0);
		rdc(12'h020, 0);
		wrc(12'h018, 4'hF, 32'hFFFFFFFF);
		rdc(12'h018, 32'hFFFFFF00);
		m_comm = 32'hFFFFFF00;
		for (i = 0; i < 8; i++) begin
			d = $urandom;
			d[7:0] = 8'h00;
			wrc(12'h018, 4'($urandom), d);
			for (int n = 1; n < 4; n++)
				if (be[n] === 1'b0) d[8*n+:8] = m_comm[8*n+:8];
			m_comm = {d[31:8], 8'h00};
			rdc(12'h018, m_comm);
			chk({8'h0, comm_o}, 32'(m_comm) >> 8);
			@(posedge clk_i);
			per_upd_i <= 1'b1;
			per_upd_addr_i <= 28'($urandom);
			ctrl_head_ld_i <= 1'b1;
			ctrl_head_ld_addr_i <= 28'($urandom);
			@(posedge clk_i);
			per_upd_i <= 1'b0;
			ctrl_head_ld_i <= 1'b0;
			m_per = {per_upd_addr_i, 4'h0};
			m_ctrl = {ctrl_head_ld_addr_i, 4'h0};
			wrc(12'h01C, 4'hF, $urandom & 32'hFFFFFFF0);
			wrc(12'h020, 4'hF, $urandom);
			wrc(12'h024, 4'hF, $urandom);
			rdc(12'h01C, m_per);
			chk({per_o, 4'h0}, 32'(m_per));
			rdc(12'h020, m_ctrl);
			chk({ctrl_o, 4'h0}, 32'(m_ctrl));
			rdc(12'h024, 0);
		end
		@(posedge clk_i);
		soft_rst_i <= 1'b1;
		@(posedge clk_i);
		soft_rst_i <= 1'b0;
		rdc(12'h018, 0);
		rdc(12'h01C, 0);
		rdc(12'h020, 0);
		final_report();
	end
endmodule
